//--- common/spime_pkg.sv
/*
 * constants shared by the serial peripheral unit and its receive fifo.
 * assumes nothing beyond a single core clock.
 */
package spime_pkg;
    // ----------------------------------------
    // data and chip select layout
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int NUM_CS = 4;
    localparam int BAUD_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 3;
    // ----------------------------------------
    // field positions in a per chip select config word
    // ----------------------------------------
    localparam int CFG_W = 16;
    localparam int CFG_CPOL_BIT = 0;
    localparam int CFG_CPHA_BIT = 1;
    localparam int CFG_INACTIVE_AFTER_BIT = 2;
    localparam int CFG_BAUD_LSB = 8;
    // ----------------------------------------
    // reset value, divisor one and last bit index
    // ----------------------------------------
    localparam logic [DATA_W-1:0] RX_RESET = 8'h00;
    localparam logic [BAUD_W-1:0] BAUD_ONE = 8'h01;
    localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [2:0] {
        SPIME_IDLE = 3'b001,
        SPIME_MXFER = 3'b010,
        SPIME_SXFER = 3'b100
    } spime_state_t;
endpackage

//--- logic/spime_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/100ps
module spime_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic flush_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] dout_q, dout_d;
    logic push, pop;

    // ----------------------------------------
    // pointer and count update
    // ----------------------------------------
    always_comb begin
        push = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
        pop = out_ready_in && (cnt_q != '0);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        dout_d = mem_q[rd_d];
        if (flush_in) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; read data leaves a register
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
        dout_q <= (push && wr_q == rd_d) ? in_data_in : dout_d;
    end

    assign in_ready_out = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_q != '0;
    assign out_data_out = dout_q;
endmodule

//--- logic/spime_core.sv
/*
 * serial peripheral unit, master or slave, with its documented defects.
 * assumes spi pins and control ports synchronous to core_clk_in.
 */
`timescale 1ns/100ps
module spime_core #(
    parameter int DATA_W = spime_pkg::DATA_W,
    parameter int NUM_CS = spime_pkg::NUM_CS
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    // control
    input wire logic enable_in,
    input wire logic disable_in,
    input wire logic master_mode_in,
    input wire logic clock_predivide_select_in,
    input wire logic [1:0] cs_select_in,
    input wire logic [spime_pkg::CFG_W*NUM_CS-1:0] per_chip_select_config_regs_in,
    // transmit holding
    input wire logic tx_write_in,
    input wire logic [DATA_W-1:0] tx_data_in,
    output logic tx_empty_out,
    // receive side
    input wire logic receive_holding_read_in,
    output logic [DATA_W-1:0] receive_holding_register_out,
    output logic receive_ready_flag_out,
    output logic enabled_out,
    // spi pins
    output logic sck_out,
    output logic sck_oe_n_out,
    output logic mosi_out,
    output logic miso_out,
    output logic [NUM_CS-1:0] cs_n_out,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic ss_n_in
);
    localparam int BW = spime_pkg::BAUD_W;

    function automatic logic [BW-1:0] baud_of(input logic [spime_pkg::CFG_W-1:0] cfg);
        baud_of = cfg[spime_pkg::CFG_BAUD_LSB +: BW];
    endfunction

    logic [spime_pkg::CFG_W-1:0] cfg;
    logic [NUM_CS-1:0] is_one;
    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_one
            assign is_one[g] = baud_of(per_chip_select_config_regs_in[g*spime_pkg::CFG_W +:
                spime_pkg::CFG_W]) == spime_pkg::BAUD_ONE;
        end
    endgenerate
    assign cfg = per_chip_select_config_regs_in[cs_select_in*spime_pkg::CFG_W +: spime_pkg::CFG_W];

    spime_pkg::spime_state_t st_q, st_d;
    logic en_q, en_d, slave_q, slave_d;
    logic [BW-1:0] div_q, div_d;
    logic [spime_pkg::CNT_W-1:0] bit_q, bit_d;
    logic [DATA_W-1:0] sh_q, sh_d, tx_q, tx_d;
    logic txf_q, txf_d;
    logic sck_q, sck_d, sckp_q, sckp_d, cpolp_q, cpolp_d, glitch_q, glitch_d, extra_q, extra_d;
    logic [NUM_CS-1:0] cs_q, cs_d;
    logic [DATA_W-1:0] rh_q;
    logic rxf_push, rxf_ready, rxf_valid, rxf_pop;
    logic [DATA_W-1:0] rxf_data;
    logic [DATA_W-1:0] rx_word;
    logic cpol, cpha, tick, s_edge, s_lead;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        cpol = cfg[spime_pkg::CFG_CPOL_BIT];
        cpha = cfg[spime_pkg::CFG_CPHA_BIT];
        st_d = st_q;
        en_d = en_q;
        slave_d = slave_q;
        div_d = div_q;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        txf_d = txf_q;
        sck_d = sck_q;
        sckp_d = sck_in;
        cpolp_d = cpol;
        glitch_d = 1'b0;
        extra_d = 1'b0;
        cs_d = cs_q;
        rxf_push = 1'b0;
        // the finished character, taken before the shifter reloads
        rx_word = {sh_q[DATA_W-2:0], mosi_in};
        tick = 1'b0;
        s_edge = (sck_in != sckp_q) && !ss_n_in && slave_q && en_q;
        s_lead = s_edge && ((sck_in ^ cpol) == 1'b1);
        if (enable_in) begin
            en_d = 1'b1;
            slave_d = !master_mode_in;
            glitch_d = !master_mode_in;
        end
        // disable has no effect in slave
        if (disable_in && !slave_q) begin
            en_d = 1'b0;
        end
        // cpol change in slave glitches too
        if (slave_q && en_q && cpol != cpolp_q) begin
            glitch_d = 1'b1;
        end
        if (tx_write_in) begin
            tx_d = tx_data_in;
            txf_d = 1'b1;
        end
        // predivide one halves the divisor wrongly
        if (div_q == '0) begin
            tick = 1'b1;
            div_d = clock_predivide_select_in ? (baud_of(cfg) >> 1) : baud_of(cfg) - 1'b1;
        end else begin
            div_d = div_q - 1'b1;
        end
        case (st_q)
            spime_pkg::SPIME_IDLE: begin
                sck_d = cpol;
                cs_d = '1;
                if (en_q && !slave_q && txf_q && tick) begin
                    sh_d = tx_q;
                    txf_d = tx_write_in;
                    bit_d = '0;
                    cs_d = ~(NUM_CS'(1) << cs_select_in);
                    // with cpol 1 and cpha 0, divisor one on some but not all selects adds one sck pulse
                    extra_d = cpol && !cpha && (|is_one) && !(&is_one);
                    st_d = spime_pkg::SPIME_MXFER;
                end else if (en_q && slave_q && !ss_n_in) begin
                    sh_d = tx_q;
                    txf_d = tx_write_in;
                    bit_d = '0;
                    st_d = spime_pkg::SPIME_SXFER;
                end
            end
            spime_pkg::SPIME_MXFER: begin
                if (tick) begin
                    sck_d = !sck_q;
                    if ((sck_q ^ cpol) == 1'b1) begin
                        sh_d = {sh_q[DATA_W-2:0], mosi_in};
                        bit_d = bit_q + 1'b1;
                        if (bit_q == spime_pkg::BIT_LAST) begin
                            rxf_push = 1'b1;
                            st_d = spime_pkg::SPIME_IDLE;
                        end
                    end
                end
            end
            spime_pkg::SPIME_SXFER: begin
                if (s_lead) begin
                    sh_d = {sh_q[DATA_W-2:0], mosi_in};
                    bit_d = bit_q + 1'b1;
                    if (bit_q == spime_pkg::BIT_LAST) begin
                        rxf_push = 1'b1;
                        sh_d = tx_q;
                        txf_d = tx_write_in;
                    end
                end
                if (ss_n_in) begin
                    st_d = spime_pkg::SPIME_IDLE;
                end
            end
            default: st_d = spime_pkg::SPIME_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= spime_pkg::SPIME_IDLE;
            en_q <= 1'b0;
            slave_q <= 1'b0;
            div_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            txf_q <= 1'b0;
            sck_q <= 1'b0;
            sckp_q <= 1'b0;
            cpolp_q <= 1'b0;
            glitch_q <= 1'b0;
            extra_q <= 1'b0;
            cs_q <= '1;
        end else if (soft_reset_in) begin
            // soft reset is the only slave stop
            st_q <= spime_pkg::SPIME_IDLE;
            en_q <= 1'b0;
            slave_q <= 1'b0;
            div_q <= '0;
            bit_q <= '0;
            txf_q <= 1'b0;
            glitch_q <= 1'b0;
            extra_q <= 1'b0;
            cs_q <= '1;
        end else begin
            st_q <= st_d;
            en_q <= en_d;
            slave_q <= slave_d;
            div_q <= div_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            txf_q <= txf_d;
            sck_q <= sck_d;
            sckp_q <= sckp_d;
            cpolp_q <= cpolp_d;
            glitch_q <= glitch_d;
            extra_q <= extra_d;
            cs_q <= cs_d;
        end
    end

    // ----------------------------------------
    // receive fifo and holding register
    // ----------------------------------------
    // fifo full stalls nothing: a full fifo drops the character, as in the part
    spime_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(spime_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .flush_in(soft_reset_in),
        .in_valid_in(rxf_push),
        .in_data_in(rx_word),
        .in_ready_out(rxf_ready),
        .out_valid_out(rxf_valid),
        .out_data_out(rxf_data),
        .out_ready_in(rxf_pop)
    );
    assign rxf_pop = rxf_valid && (!receive_ready_flag_out || receive_holding_read_in);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rh_q <= spime_pkg::RX_RESET;
            receive_ready_flag_out <= 1'b0;
        end else if (soft_reset_in) begin
            // soft reset drops a stale ready so the unit restarts clean
            receive_ready_flag_out <= 1'b0;
        end else begin
            if (rxf_pop) begin
                rh_q <= rxf_data;
            end
            // set wins over clear; glitch sets it too
            receive_ready_flag_out <= rxf_pop || glitch_q ||
                (receive_ready_flag_out && !receive_holding_read_in);
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_out <= 1'b0;
            sck_oe_n_out <= 1'b1;
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
            cs_n_out <= '1;
            tx_empty_out <= 1'b1;
            enabled_out <= 1'b0;
        end else begin
            // extra pulse on pin only
            // inverting the pin, not sck_q, keeps the bit timing intact
            sck_out <= extra_q ? !sck_q : sck_q;
            sck_oe_n_out <= !(en_q && !slave_q);
            mosi_out <= sh_q[DATA_W-1];
            miso_out <= sh_q[DATA_W-1];
            cs_n_out <= cs_q;
            tx_empty_out <= !txf_q;
            enabled_out <= en_q;
        end
    end
    assign receive_holding_register_out = rh_q;
    logic unused;
    assign unused = rxf_ready;
endmodule

//--- bench/spime_core_props.sv
/*
 * concurrent checks on the serial unit's ports.
 * assumes a single core clock and the active low async reset.
 */
`timescale 1ns/100ps
module spime_core_props #(
    parameter int NUM_CS = 4
) (
    // ----------------------------------------
    // watched ports
    // ----------------------------------------
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    input wire logic enable_in,
    input wire logic disable_in,
    input wire logic master_mode_in,
    input wire logic tx_write_in,
    input wire logic receive_holding_read_in,
    input wire logic ss_n_in,
    input wire logic enabled_out,
    input wire logic receive_ready_flag_out,
    input wire logic tx_empty_out,
    input wire logic sck_oe_n_out,
    input wire logic [NUM_CS-1:0] cs_n_out
);
    // mode is latched at the enable pulse, as the unit does
    logic slave_q;
    logic slave_d;
    always_comb begin
        slave_d = slave_q;
        if (enable_in) begin
            slave_d = !master_mode_in;
        end
        if (soft_reset_in) begin
            slave_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slave_q <= 1'b0;
        end else begin
            slave_q <= slave_d;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    enable_on_a: assert property (
        enable_in && !soft_reset_in && !disable_in |-> ##2 enabled_out)
        else $error("enable not seen after two cycles");
    slave_disable_a: assert property (
        disable_in && enabled_out && slave_q && !soft_reset_in |=> enabled_out [*3])
        else $error("slave unit stopped on disable");
    soft_reset_a: assert property (
        soft_reset_in |=> !receive_ready_flag_out ##1 !enabled_out)
        else $error("soft reset left unit running");
    tx_quiet_a: assert property (
        slave_q && tx_empty_out && !tx_write_in && !$past(tx_write_in) |=> tx_empty_out)
        else $error("slave transmit status moved without a write");
    read_clear_a: assert property (
        receive_holding_read_in && slave_q && ss_n_in && !enable_in |=> !receive_ready_flag_out)
        else $error("receive ready stuck after read");
    sel_onehot_a: assert property (
        $onehot0(~cs_n_out))
        else $error("more than one select low");
    master_clk_a: assert property (
        !slave_q && !(&cs_n_out) |-> !sck_oe_n_out)
        else $error("select low without driving the clock");
endmodule
bind spime_core spime_core_props #(.NUM_CS(NUM_CS)) u_props (.core_clk_in, .arst_n_in,
    .soft_reset_in, .enable_in, .disable_in, .master_mode_in, .tx_write_in,
    .receive_holding_read_in, .ss_n_in, .enabled_out, .receive_ready_flag_out, .tx_empty_out,
    .sck_oe_n_out, .cs_n_out);

//--- bench/spime_far_dev.sv
/*
 * far side: spi slave answering the unit, or master sending a frame.
 * assumes cpol 0, cpha 0 for the data it checks.
 */
`timescale 1ns/100ps
module spime_far_dev (
    // pacing
    input wire logic core_clk_in,
    // from the unit
    input wire logic dev_sck_in,
    input wire logic [3:0] dev_cs_n_in,
    input wire logic dev_mosi_in,
    // to the unit
    output logic sck_out,
    output logic ss_n_out,
    output logic data_out
);
    logic [7:0] resp_q = 8'h3C;
    logic [7:0] got_q = 8'h00;
    logic [7:0] sh = 8'h00;
    logic drive_frame = 1'b0;
    initial begin
        sck_out = 1'b0;
        ss_n_out = 1'b1;
        data_out = 1'b0;
    end
    // released line flips, so a stale bit never looks valid
    always @(dev_cs_n_in) begin
        if (!drive_frame) begin
            sh = resp_q;
            data_out = (&dev_cs_n_in) ? ~data_out : sh[7];
        end
    end
    always @(posedge dev_sck_in) begin
        if (!(&dev_cs_n_in)) begin
            got_q = {got_q[6:0], dev_mosi_in};
        end
    end
    always @(negedge dev_sck_in) begin
        if (!(&dev_cs_n_in) && !drive_frame) begin
            sh = {sh[6:0], 1'b0};
            data_out = sh[7];
        end
    end
    // clock stands still outside the frame
    task automatic send(input logic [7:0] b);
        drive_frame = 1'b1;
        ss_n_out = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            data_out = b[i];
            repeat (4) @(posedge core_clk_in);
            #1 sck_out = 1'b1;
            repeat (4) @(posedge core_clk_in);
            #1 sck_out = 1'b0;
        end
        repeat (4) @(posedge core_clk_in);
        #1 ss_n_out = 1'b1;
        data_out = ~data_out;
        drive_frame = 1'b0;
    endtask
endmodule

//--- bench/spime_core_tb_top.sv
/*
 * self-checking bench for the serial unit and its fifo.
 * assumes the far side model and the bound checker.
 */
`timescale 1ns/100ps
module spime_core_tb_top;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic enable_in = 1'b0;
    logic disable_in = 1'b0;
    logic master_mode_in = 1'b1;
    logic predivide = 1'b0;
    logic [1:0] cs_sel = 2'h0;
    logic [63:0] cfg = 64'h0;
    logic tx_write_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rx_data;
    logic rx_rdy, en_q, tx_empty, sck, sck_oe_n, mosi, sck_far, ss_n, far_data;
    logic [3:0] cs_n;
    int err_count = 0;
    int checked = 0;
    int toggles = 0;
    always #4 core_clk_in = ~core_clk_in;
    always @(sck) toggles++;
    spime_core uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .soft_reset_in(soft_reset_in), .enable_in(enable_in), .disable_in(disable_in),
        .master_mode_in(master_mode_in), .clock_predivide_select_in(predivide),
        .cs_select_in(cs_sel), .per_chip_select_config_regs_in(cfg), .tx_write_in(tx_write_in),
        .tx_data_in(tx_data_in), .tx_empty_out(tx_empty), .receive_holding_read_in(rd),
        .receive_holding_register_out(rx_data), .receive_ready_flag_out(rx_rdy),
        .enabled_out(en_q), .sck_out(sck), .sck_oe_n_out(sck_oe_n), .mosi_out(mosi),
        .miso_out(), .cs_n_out(cs_n), .sck_in(sck_far), .mosi_in(far_data), .ss_n_in(ss_n));
    spime_far_dev far (.core_clk_in(core_clk_in), .dev_sck_in(sck), .dev_cs_n_in(cs_n),
        .dev_mosi_in(mosi), .sck_out(sck_far), .ss_n_out(ss_n), .data_out(far_data));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("counts: %0d compared, %0d mismatched", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (rx_rdy !== 1'b1 && n < 4000) begin
            tick(1);
            n++;
        end
        if (n >= 4000) begin
            check(16'h0, 16'h1);
            test_done;
        end
    endtask
    task automatic xfer(input logic [7:0] b, output int n);
        tx_data_in = b;
        pulse(tx_write_in);
        wait_ready(n);
        tick(4);
    endtask
    function automatic logic [63:0] mk(logic pol, logic [7:0] b0, logic [7:0] b1, logic nb);
        logic [15:0] w0;
        logic [15:0] w1;
        w0 = {b0, 5'h00, nb, 1'b0, pol};
        w1 = {b1, 5'h00, nb, 1'b0, pol};
        return {w1, w1, w1, w0};
    endfunction
    task automatic t_master;
        int n;
        cfg = mk(1'b0, 8'h02, 8'h02, 1'b0);
        pulse(enable_in);
        tick(2);
        check(en_q, 1'b1);
        xfer(8'hA5, n);
        check(rx_data, 8'h3C);
        check(far.got_q, 8'hA5);
        pulse(rd);
        tick(1);
        check(rx_rdy, 1'b0);
        cfg = mk(1'b0, 8'h02, 8'h02, 1'b1);
        xfer(8'h5A, n);
        check(cs_n, 4'hF);
        pulse(rd);
        $display("master transfer test done");
    endtask
    task automatic t_pulse;
        int n;
        cfg = mk(1'b1, 8'h01, 8'h01, 1'b0);
        tick(4);
        toggles = 0;
        xfer(8'h81, n);
        check(16'(toggles), 16'h0010);
        pulse(rd);
        cfg = mk(1'b1, 8'h01, 8'h02, 1'b0);
        cs_sel = 2'h1;
        tick(4);
        toggles = 0;
        xfer(8'h81, n);
        check(16'(toggles), 16'h0012);
        pulse(rd);
        cs_sel = 2'h0;
        $display("extra clock pulse test done");
    endtask
    task automatic t_predivide;
        int n0;
        int n1;
        // divisor four: the faulty predivide path runs visibly faster
        cfg = mk(1'b0, 8'h04, 8'h04, 1'b0);
        tick(4);
        xfer(8'h11, n0);
        pulse(rd);
        predivide = 1'b1;
        xfer(8'h22, n1);
        pulse(rd);
        predivide = 1'b0;
        check(16'(n1 < n0), 16'h0001);
        $display("predivide test done");
    endtask
    task automatic t_slave;
        int n;
        pulse(soft_reset_in);
        master_mode_in = 1'b0;
        pulse(enable_in);
        tick(2);
        cfg = mk(1'b1, 8'h02, 8'h02, 1'b0);
        tick(2);
        cfg = mk(1'b0, 8'h02, 8'h02, 1'b0);
        tick(2);
        pulse(rd);
        tick(1);
        check(rx_rdy, 1'b0);
        far.send(8'h5A);
        wait_ready(n);
        check(rx_data, 8'h5A);
        check(tx_empty, 1'b1);
        pulse(disable_in);
        tick(3);
        check(en_q, 1'b1);
        pulse(rd);
        pulse(soft_reset_in);
        tick(2);
        check(en_q, 1'b0);
        $display("slave test done");
    endtask
    task automatic t_fifo;
        master_mode_in = 1'b1;
        cfg = mk(1'b0, 8'h01, 8'h01, 1'b0);
        pulse(enable_in);
        tick(2);
        check(en_q, 1'b1);
        // six frames unread: holding takes one, fifo four, the sixth is lost
        for (int i = 0; i < 6; i++) begin
            far.resp_q = 8'h10 + 8'(i);
            tx_data_in = 8'h20 + 8'(i);
            pulse(tx_write_in);
            tick(40);
            check(far.got_q, 8'h20 + 8'(i));
        end
        check(rx_rdy, 1'b1);
        check(rx_data, 8'h10);
        for (int i = 1; i < 5; i++) begin
            pulse(rd);
            check(rx_data, 8'h10 + 8'(i));
            check(rx_rdy, 1'b1);
            tick(1);
        end
        pulse(rd);
        tick(1);
        check(rx_rdy, 1'b0);
        check(rx_data, 8'h14);
        $display("fifo test done");
    endtask
    initial begin
        tick(10);
        arst_n_in = 1'b1;
        check(cs_n, 4'hF);
        check(sck_oe_n, 1'b1);
        check(tx_empty, 1'b1);
        check(rx_rdy, 1'b0);
        $display("reset test done");
        t_master;
        t_pulse;
        t_predivide;
        t_slave;
        t_fifo;
        test_done;
    end
endmodule
